//--- rtl/rie_pkg.sv
/*
  constants for the radio interrupt enable register bank: offsets, event bit
  positions, reset value and bus answer codes.
  assumes a 32-bit register bus with byte addressing.
*/
package rie_pkg;

  localparam int unsigned RIE_ADDR_W        = 12;
  localparam logic [11:0] RIE_OFF_ENABLE_SET = 12'h304;
  localparam logic [11:0] RIE_OFF_ENABLE_CLR = 12'h308;
  localparam logic [31:0] RIE_ENABLE_RESET   = 32'h0000_0000;

  // event bit positions inside the enable word
  localparam int unsigned RIE_BIT_READY      = 0;
  localparam int unsigned RIE_BIT_ADDRESS    = 1;
  localparam int unsigned RIE_BIT_PAYLOAD    = 2;
  localparam int unsigned RIE_BIT_END        = 3;
  localparam int unsigned RIE_BIT_DISABLED   = 4;
  localparam int unsigned RIE_BIT_DEV_HIT    = 5;
  localparam int unsigned RIE_BIT_DEV_MISS   = 6;
  localparam int unsigned RIE_BIT_SIG_DONE   = 7;
  localparam int unsigned RIE_BIT_BITCNT_HIT = 10;
  localparam int unsigned RIE_BIT_CRC_PASS   = 12;
  localparam int unsigned RIE_BIT_CRC_FAIL   = 13;
  localparam int unsigned RIE_BIT_FRAME      = 14;
  localparam int unsigned RIE_BIT_ED_DONE    = 15;
  localparam int unsigned RIE_BIT_ED_HALT    = 16;
  localparam int unsigned RIE_BIT_CCA_IDLE   = 17;
  localparam int unsigned RIE_BIT_CCA_BUSY   = 18;
  localparam int unsigned RIE_BIT_CCA_HALT   = 19;
  localparam int unsigned RIE_BIT_RATE_BOOST = 20;
  localparam int unsigned RIE_BIT_TX_READY   = 21;
  localparam int unsigned RIE_BIT_RX_READY   = 22;
  localparam int unsigned RIE_BIT_HDR_MATCH  = 23;
  localparam int unsigned RIE_BIT_PHY_END    = 27;
  localparam int unsigned RIE_BIT_TONE       = 28;

  // implemented bits; all others read as zero
  localparam logic [31:0] RIE_VALID_MASK = 32'h18ff_f4ff;

  localparam logic [1:0] RIE_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RIE_RESP_SLVERR = 2'h2;

endpackage : rie_pkg

//--- rtl/rie_enable_bank.sv
/*
  interrupt enable bank of the radio: write-one-to-set and write-one-to-clear
  views of one shared enable word behind an axi4-lite slave, plus per-event
  gating of the raw radio events.
  assumes event pulses and the bus are synchronous to clock.
*/
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rie_enable_bank
  import rie_pkg::*;
#(
  parameter int unsigned ADDR_W = RIE_ADDR_W
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [31:0]       radioEvents,
  output logic [31:0]            irqEnable,
  output logic [31:0]            maskedEvents,
  output logic                   irqRequest
);

  logic              awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHeld_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              bValid_q;
  logic [1:0]        bResp_q;
  logic              rValid_q;
  logic [31:0]       rData_q;
  logic [1:0]        rResp_q;
  logic [31:0]       enable_q;
  logic [31:0]       masked_q;
  logic              irq_q;
  logic              wrDo;
  logic              wrSet;
  logic              wrClr;
  logic [31:0]       wrBits;
  logic              arTake;
  logic [ADDR_W-1:0] offSet;
  logic [ADDR_W-1:0] offClr;

  assign offSet = RIE_OFF_ENABLE_SET[ADDR_W-1:0];
  assign offClr = RIE_OFF_ENABLE_CLR[ADDR_W-1:0];

  // address and data are taken independently; no new pair until b is taken
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
  assign irqEnable     = enable_q;
  assign maskedEvents  = masked_q;
  assign irqRequest    = irq_q;

  assign wrDo   = awHeld_q && wHeld_q && !bValid_q;
  assign wrSet  = wrDo && (awAddr_q[ADDR_W-1:2] == offSet[ADDR_W-1:2]);
  assign wrClr  = wrDo && (awAddr_q[ADDR_W-1:2] == offClr[ADDR_W-1:2]);
  assign arTake = s_axi_arvalid && s_axi_arready;
  // byte lanes limit which enables a write may touch
  assign wrBits = wData_q & RIE_VALID_MASK &
                  {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (wrDo) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (wrDo) begin
      wHeld_q <= 1'b0;
    end
  end

  // unmapped writes are dropped but answered with an error
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bValid_q <= 1'b0;
      bResp_q  <= RIE_RESP_OKAY;
    end else if (wrDo) begin
      bValid_q <= 1'b1;
      bResp_q  <= (wrSet || wrClr) ? RIE_RESP_OKAY : RIE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // both offsets read back the same shared enable word
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rValid_q <= 1'b0;
      rData_q  <= '0;
      rResp_q  <= RIE_RESP_OKAY;
    end else if (arTake) begin
      rValid_q <= 1'b1;
      if (s_axi_araddr[ADDR_W-1:2] == offSet[ADDR_W-1:2] ||
          s_axi_araddr[ADDR_W-1:2] == offClr[ADDR_W-1:2]) begin
        rData_q <= enable_q;
        rResp_q <= RIE_RESP_OKAY;
      end else begin
        rData_q <= '0;
        rResp_q <= RIE_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  // one flop per event; unimplemented positions stay zero
  for (genvar i = 0; i < 32; i++) begin : g_enable
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        enable_q[i] <= RIE_ENABLE_RESET[i];
      end else if (RIE_VALID_MASK[i] && wrClr && wrBits[i]) begin
        enable_q[i] <= 1'b0;
      end else if (RIE_VALID_MASK[i] && wrSet && wrBits[i]) begin
        enable_q[i] <= 1'b1;
      end
    end
  end

  // gating is registered so the interrupt line is glitch free
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      masked_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      masked_q <= radioEvents & enable_q;
      irq_q    <= |(radioEvents & enable_q);
    end
  end

  a_clear_takes_effect: assert property (
    @(posedge clock) disable iff (!reset_n)
    wrClr |=> ((enable_q & $past(wrBits)) == 32'h0000_0000))
    else $error("clear write left an enable set");

  a_zero_keeps_state: assert property (
    @(posedge clock) disable iff (!reset_n)
    (wrClr || wrSet) |=> ((enable_q & ~$past(wrBits)) == ($past(enable_q) & ~$past(wrBits))))
    else $error("zero bits of a write changed an enable");

  a_set_shared_state: assert property (
    @(posedge clock) disable iff (!reset_n)
    wrSet |=> ((enable_q & $past(wrBits)) == $past(wrBits)))
    else $error("set write did not enable its bits");

  a_read_returns_state: assert property (
    @(posedge clock) disable iff (!reset_n)
    (arTake && s_axi_araddr[ADDR_W-1:2] == offClr[ADDR_W-1:2])
      |=> (s_axi_rvalid && s_axi_rdata == $past(enable_q)))
    else $error("read of clear register differs from enable state");

  a_reset_all_masked: assert property (
    @(posedge clock) $rose(reset_n) |-> (enable_q == 32'h0000_0000 && !irqRequest))
    else $error("enables not cleared by reset");

  a_sig_done_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_SIG_DONE] && enable_q[RIE_BIT_SIG_DONE])
      |=> (maskedEvents[RIE_BIT_SIG_DONE] && irqRequest))
    else $error("enabled sample done event not passed");

  a_bitcnt_blocked: assert property (
    @(posedge clock) disable iff (!reset_n)
    !enable_q[RIE_BIT_BITCNT_HIT] |=> !maskedEvents[RIE_BIT_BITCNT_HIT])
    else $error("disabled bit counter event passed");

  a_crc_separate: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_CRC_PASS] && radioEvents[RIE_BIT_CRC_FAIL] &&
     enable_q[RIE_BIT_CRC_PASS] && !enable_q[RIE_BIT_CRC_FAIL])
      |=> (maskedEvents[RIE_BIT_CRC_PASS] && !maskedEvents[RIE_BIT_CRC_FAIL]))
    else $error("crc events not masked separately");

  a_energy_separate: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_ED_HALT] && enable_q[RIE_BIT_ED_HALT] && !enable_q[RIE_BIT_ED_DONE])
      |=> (maskedEvents[RIE_BIT_ED_HALT] && !maskedEvents[RIE_BIT_ED_DONE]))
    else $error("energy detect events not masked separately");

  a_cca_busy_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_CCA_BUSY] && enable_q[RIE_BIT_CCA_BUSY] &&
     !enable_q[RIE_BIT_CCA_IDLE] && !enable_q[RIE_BIT_CCA_HALT])
      |=> (maskedEvents[RIE_BIT_CCA_BUSY] && !maskedEvents[RIE_BIT_CCA_IDLE] &&
           !maskedEvents[RIE_BIT_CCA_HALT]))
    else $error("channel assess events not masked separately");

  a_dev_miss_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_DEV_MISS] && enable_q[RIE_BIT_DEV_MISS])
      |=> maskedEvents[RIE_BIT_DEV_MISS])
    else $error("enabled address miss event not passed");

  a_tx_ready_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    !enable_q[RIE_BIT_TX_READY] |=> !maskedEvents[RIE_BIT_TX_READY])
    else $error("disabled transmit ready event passed");

  a_bresp_holds: assert property (
    @(posedge clock) disable iff (!reset_n)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before taken");

  a_rresp_holds: assert property (
    @(posedge clock) disable iff (!reset_n)
    (s_axi_rvalid && !s_axi_rready)
      |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read response dropped or changed before taken");

  a_bad_write_kept: assert property (
    @(posedge clock) disable iff (!reset_n)
    (wrDo && !wrSet && !wrClr) |=> (enable_q == $past(enable_q)))
    else $error("unmapped write changed the enable word");

  a_bad_write_error: assert property (
    @(posedge clock) disable iff (!reset_n)
    (wrDo && !wrSet && !wrClr) |=> (s_axi_bvalid && s_axi_bresp == RIE_RESP_SLVERR))
    else $error("unmapped write not answered with an error");

  a_good_write_okay: assert property (
    @(posedge clock) disable iff (!reset_n)
    (wrSet || wrClr) |=> (s_axi_bvalid && s_axi_bresp == RIE_RESP_OKAY))
    else $error("mapped write not answered with okay");

  a_set_view_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    (arTake && s_axi_araddr[ADDR_W-1:2] == offSet[ADDR_W-1:2])
      |=> (s_axi_rvalid && s_axi_rdata == $past(enable_q)))
    else $error("read of set register differs from enable state");

  a_unused_stay_low: assert property (
    @(posedge clock) disable iff (!reset_n)
    (irqEnable & ~RIE_VALID_MASK) == 32'h0000_0000)
    else $error("unimplemented enable bit became set");

  a_bitcnt_passes: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_BITCNT_HIT] && enable_q[RIE_BIT_BITCNT_HIT])
      |=> maskedEvents[RIE_BIT_BITCNT_HIT])
    else $error("enabled bit counter event not passed");

  a_crc_fail_alone: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_CRC_FAIL] && enable_q[RIE_BIT_CRC_FAIL] &&
     !enable_q[RIE_BIT_CRC_PASS])
      |=> (maskedEvents[RIE_BIT_CRC_FAIL] && !maskedEvents[RIE_BIT_CRC_PASS]))
    else $error("crc fail event not masked separately");

  a_ed_done_alone: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_ED_DONE] && enable_q[RIE_BIT_ED_DONE] &&
     !enable_q[RIE_BIT_ED_HALT])
      |=> (maskedEvents[RIE_BIT_ED_DONE] && !maskedEvents[RIE_BIT_ED_HALT]))
    else $error("energy detect done not masked separately");

  a_cca_idle_alone: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_CCA_IDLE] && enable_q[RIE_BIT_CCA_IDLE] &&
     !enable_q[RIE_BIT_CCA_BUSY] && !enable_q[RIE_BIT_CCA_HALT])
      |=> (maskedEvents[RIE_BIT_CCA_IDLE] && !maskedEvents[RIE_BIT_CCA_BUSY]))
    else $error("channel assess idle not masked separately");

  a_cca_halt_alone: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_CCA_HALT] && enable_q[RIE_BIT_CCA_HALT] &&
     !enable_q[RIE_BIT_CCA_IDLE] && !enable_q[RIE_BIT_CCA_BUSY])
      |=> (maskedEvents[RIE_BIT_CCA_HALT] && !maskedEvents[RIE_BIT_CCA_IDLE]))
    else $error("channel assess halted not masked separately");

  a_rx_ready_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    (radioEvents[RIE_BIT_RX_READY] && enable_q[RIE_BIT_RX_READY])
      |=> maskedEvents[RIE_BIT_RX_READY])
    else $error("enabled receive ready event not passed");

endmodule : rie_enable_bank

`default_nettype wire

//--- bench/rie_enable_bank_bench.sv
/*
  self-checking bench for the radio interrupt enable bank: axi4-lite read and
  write tasks, enable set and clear sequences, event gating checks.
  assumes rie_pkg and rie_enable_bank are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rie_enable_bank_bench;
  import rie_pkg::*;
  logic        clock, reset_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, radioEvents, irqEnable, maskedEvents, en, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irqRequest;
  int          failCount, numChecks;

  rie_enable_bank rie_enable_bank_i (
    .clock(clock), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .radioEvents(radioEvents),
    .irqEnable(irqEnable), .maskedEvents(maskedEvents), .irqRequest(irqRequest)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // readies sampled at the falling edge, so the rising edge sees the same values
  // response ready comes late on purpose, so the slave must hold its answer
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw, bw, bv;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bw = bvalid;
      bv = bvalid && bready;
      r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (bw && !bv) bready <= 1'b1;
    end while (!bv);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    logic ta, rw, rv;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clock);
      ta = arvalid && arready;
      rw = rvalid;
      rv = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (rw && !rv) rready <= 1'b1;
    end while (!rv);
    rready <= 1'b0;
  endtask

  // gated outputs lag the enable word by one cycle
  task automatic look();
    @(posedge clock);
    @(negedge clock);
    chk("irqEnable", irqEnable, en);
    chk("maskedEvents", maskedEvents, radioEvents & en);
    chk("irqRequest", 32'(irqRequest), 32'(|(radioEvents & en)));
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    failCount++;
    closeOut();
  end

  initial begin
    {reset_n, awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
    {arvalid, rready} = '0;
    radioEvents = 32'hffff_ffff;
    en = RIE_ENABLE_RESET;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd(RIE_OFF_ENABLE_CLR);
    chk("clrReadReset", d, en);
    look();
    // every bit, unimplemented ones must never stick
    for (int i = 0; i < 32; i++) begin
      wr(RIE_OFF_ENABLE_SET, 32'h1 << i, 4'hf);
      en = en | ((32'h1 << i) & RIE_VALID_MASK);
      look();
      rd(RIE_OFF_ENABLE_CLR);
      chk("clrRead", d, en);
    end
    chk("allSet", d, 32'h18ff_f4ff);
    wr(RIE_OFF_ENABLE_CLR, 32'h0, 4'hf);
    look();
    wr(RIE_OFF_ENABLE_CLR, 32'hffff_ffff, 4'h1);
    en = en & 32'hffff_ff00;
    chk("bresp", 32'(r), 32'(RIE_RESP_OKAY));
    look();
    wr(12'h30c, 32'hffff_ffff, 4'hf);
    chk("brespBad", 32'(r), 32'(RIE_RESP_SLVERR));
    look();
    rd(12'h30c);
    chk("rdataBad", d, 32'h0);
    chk("rrespBad", 32'(r), 32'(RIE_RESP_SLVERR));
    for (int i = 8; i < 32; i++) begin
      wr(RIE_OFF_ENABLE_CLR, 32'h1 << i, 4'hf);
      en = en & ~(32'h1 << i);
      look();
      rd(RIE_OFF_ENABLE_SET);
      chk("setRead", d, en);
    end
    wr(RIE_OFF_ENABLE_SET, 32'h1 << RIE_BIT_CCA_BUSY, 4'hf);
    en = en | (32'h1 << RIE_BIT_CCA_BUSY);
    look();
    // quiet radio with all enables on: no request may appear
    @(posedge clock);
    radioEvents <= 32'h0;
    wr(RIE_OFF_ENABLE_SET, 32'hffff_ffff, 4'hf);
    en = RIE_VALID_MASK;
    look();
    @(posedge clock);
    reset_n <= 1'b0;
    en = RIE_ENABLE_RESET;
    @(negedge clock);
    chk("irqEnableReset", irqEnable, en);
    @(posedge clock);
    reset_n <= 1'b1;
    rd(RIE_OFF_ENABLE_CLR);
    chk("clrReadAfterReset", d, en);
    look();
    closeOut();
  end
endmodule // rie_enable_bank_bench
`default_nettype wire
